/* rtl/bid_alu.v */
// Combinational arithmetic unit of the instruction executor.
`timescale 1ns/1ps
`include "bid_consts.vh"

module bid_alu (
  // Operation select.
  input wire [3:0] op_in,
  input wire [2:0] bit_idx_in,
  // Operands.
  input wire [7:0] acc_in,
  input wire [7:0] opnd_in,
  input wire carry_in,
  // Results.
  output reg [7:0] res_out,
  output reg carry_out,
  output reg dcarry_out
);

  reg [8:0] sum;
  reg [4:0] low;
  reg [7:0] mask;

  always @* begin
    sum = 9'h000;
    low = 5'h00;
    mask = 8'h01 << bit_idx_in;
    res_out = 8'h00;
    carry_out = carry_in;
    dcarry_out = 1'b0;
    case (op_in)
      `BID_OP_ADD: begin
        sum = {1'b0, opnd_in} + {1'b0, acc_in};
        low = {1'b0, opnd_in[3:0]} + {1'b0, acc_in[3:0]};
        res_out = sum[7:0];
        carry_out = sum[8];
        dcarry_out = low[4];
      end
      `BID_OP_SUB: begin
        sum = {1'b0, opnd_in} + {1'b0, ~acc_in} + 9'h001;
        low = {1'b0, opnd_in[3:0]} + {1'b0, ~acc_in[3:0]} + 5'h01;
        res_out = sum[7:0];
        carry_out = sum[8];
        dcarry_out = low[4];
      end
      `BID_OP_AND: res_out = acc_in & opnd_in;
      `BID_OP_OR: res_out = acc_in | opnd_in;
      `BID_OP_XOR: res_out = acc_in ^ opnd_in;
      `BID_OP_CLR: res_out = 8'h00;
      `BID_OP_COM: res_out = ~opnd_in;
      `BID_OP_DEC: res_out = opnd_in - 8'h01;
      `BID_OP_INC: res_out = opnd_in + 8'h01;
      `BID_OP_MOVB: res_out = opnd_in;
      `BID_OP_RL: begin
        res_out = {opnd_in[6:0], carry_in};
        carry_out = opnd_in[7];
      end
      `BID_OP_RR: begin
        res_out = {carry_in, opnd_in[7:1]};
        carry_out = opnd_in[0];
      end
      `BID_OP_SWAP: res_out = {opnd_in[3:0], opnd_in[7:4]};
      `BID_OP_BCLR: res_out = opnd_in & ~mask;
      `BID_OP_BSET: res_out = opnd_in | mask;
      default: res_out = acc_in;
    endcase
  end

endmodule // bid_alu

/* rtl/bid_consts.vh */
// Constants for the 12-bit instruction decoder and executor.
`ifndef BID_CONSTS_VH
`define BID_CONSTS_VH

// Timing: oscillator periods per instruction cycle.
`define BID_OSC_PER_CYC 4
`define BID_PH_W 2

// Widths.
`define BID_PC_W 9
`define BID_INSTR_W 12

// File register addresses the core treats specially.
`define BID_ADDR_TMR 5'h01
`define BID_ADDR_PCL 5'h02
`define BID_ADDR_PORT 5'h06
`define BID_PIN_DIRECTION_LOAD_PORT 3'h6

// Reset values.
`define BID_PC_RST 9'h1ff
`define BID_W_RST 8'h00
`define BID_PIN_DIRECTION_LOAD_RST 8'hff
`define BID_OPT_RST 8'hff

// Configuration register field: prescaler owner, 0 means the timer.
`define BID_OPT_PSA 3

// Fixed control words.
`define BID_I_NOP 12'h000
`define BID_I_OPTION 12'h002
`define BID_I_SLEEP 12'h003
`define BID_I_KICK 12'h004

// Arithmetic unit operation codes.
`define BID_OP_ADD 4'h0
`define BID_OP_SUB 4'h1
`define BID_OP_AND 4'h2
`define BID_OP_OR 4'h3
`define BID_OP_XOR 4'h4
`define BID_OP_CLR 4'h5
`define BID_OP_COM 4'h6
`define BID_OP_DEC 4'h7
`define BID_OP_INC 4'h8
`define BID_OP_MOVB 4'h9
`define BID_OP_RL 4'ha
`define BID_OP_RR 4'hb
`define BID_OP_SWAP 4'hc
`define BID_OP_BCLR 4'hd
`define BID_OP_BSET 4'he
`define BID_OP_MOVA 4'hf

`endif

/* rtl/bid_decoder.v */
// Decoder and executor for 12-bit instruction words of a small 8-bit core.
// Operation
// - d=0 writes accumulator, d=1 writes file.
// - Add accumulator and file; carry, digit carry, zero.
// - OR, AND, XOR with file update zero only.
// - Decrement/increment, skip on zero, flags untouched.
// - Rotate left/right through carry, carry only.
// - Bit clear/set in file, flags untouched.
// - Bit test skips on clear/set, no flags.
// - Literal AND/OR/XOR into accumulator, zero only.
// - Call takes two cycles; PC bit 8 cleared.
// - Jump loads nine-bit target, two cycles.
// - Return loads literal into accumulator, two cycles.
// - Watchdog kick clears watchdog, updates timeout and powerdown.
// - Sleep enters standby, updates timeout and powerdown flags.
// - Option word loads configuration in one cycle.
// - Direction load to port six sets tristate.
// - Port self-modify uses pin levels as operand.
// - Timer write, except complement, clears prescaler when timer owns it.
// - One cycle is four clocks; skips/branches two.
`timescale 1ns/1ps
`include "bid_consts.vh"

module bid_decoder #(
  parameter OSC_PER_CYC = `BID_OSC_PER_CYC
) (
  // Clock and reset.
  input wire clock_in,
  input wire srst_in,
  // Instruction fetch.
  input wire [11:0] instr_in,
  output wire [8:0] pc_out,
  output wire cycle_out,
  // File register access.
  output wire [4:0] file_raddr_out,
  input wire [7:0] file_rdata_in,
  output reg [4:0] file_waddr_out,
  output reg [7:0] file_wdata_out,
  output reg file_we_out,
  // Port pins.
  input wire [7:0] port_pins_in,
  output wire [7:0] pin_direction_load_out,
  // Core state.
  output wire [7:0] acc_out,
  output wire carry_out,
  output wire digit_carry_flag_out,
  output wire zero_out,
  output wire timeout_flag_out,
  output wire powerdown_flag_out,
  output wire [7:0] option_out,
  // Side effects.
  output reg prescaler_clear_out,
  output reg watchdog_kick_out,
  input wire wake_in,
  output wire sleep_out
);

  localparam ST_RUN = 3'b001;
  localparam ST_FLUSH = 3'b010;
  localparam ST_SLEEP = 3'b100;

  reg [`BID_PH_W-1:0] ph_r;
  reg [2:0] st_r;
  reg [8:0] pc_r;
  reg [8:0] stk_r [0:1];
  reg [7:0] acc_r;
  reg c_r;
  reg dc_r;
  reg z_r;
  reg to_r;
  reg pd_r;
  reg [7:0] opt_r;
  reg [7:0] pin_direction_load_r;

  wire ce;
  wire d_bit;
  wire [4:0] faddr;
  wire [7:0] lit;
  wire [7:0] fval;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire bit_val;

  // Decode outputs.
  reg [3:0] op;
  reg use_lit;
  reg wr_acc;
  reg wr_file;
  reg upd_c;
  reg upd_dc;
  reg upd_z;
  reg skip_zero;
  reg skip_clr;
  reg skip_set;
  reg is_call;
  reg is_unconditional_jump;
  reg is_ret;
  reg is_kick;
  reg is_sleep;
  reg is_opt;
  reg is_pin_direction_load;
  reg note_tmr;

  // Execute-time derived terms.
  reg skip;
  reg [8:0] pc_nxt;
  reg [2:0] st_nxt;

  // Instruction cycle enable: one pulse per four oscillator periods.
  assign ce = (ph_r == OSC_PER_CYC - 1);

  always @(posedge clock_in) begin
    if (srst_in || ce) begin
      ph_r <= {`BID_PH_W{1'b0}};
    end else begin
      ph_r <= ph_r + {{(`BID_PH_W-1){1'b0}}, 1'b1};
    end
  end

  assign d_bit = instr_in[5];
  assign faddr = instr_in[4:0];
  assign lit = instr_in[7:0];
  assign file_raddr_out = faddr;
  assign fval = (faddr == `BID_ADDR_PORT) ? port_pins_in : file_rdata_in;
  assign bit_val = fval[instr_in[7:5]];

  always @* begin
    op = `BID_OP_MOVA;
    use_lit = 1'b0;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    skip_zero = 1'b0;
    skip_clr = 1'b0;
    skip_set = 1'b0;
    is_call = 1'b0;
    is_unconditional_jump = 1'b0;
    is_ret = 1'b0;
    is_kick = 1'b0;
    is_sleep = 1'b0;
    is_opt = 1'b0;
    is_pin_direction_load = 1'b0;
    note_tmr = 1'b1;
    case (instr_in[11:10])
      2'b00: begin
        wr_acc = ~d_bit;
        wr_file = d_bit;
        upd_z = 1'b1;
        case (instr_in[9:6])
          4'h0: begin
            wr_acc = 1'b0;
            upd_z = 1'b0;
            wr_file = d_bit;
            if (!d_bit) begin
              is_opt = (instr_in == `BID_I_OPTION);
              is_sleep = (instr_in == `BID_I_SLEEP);
              is_kick = (instr_in == `BID_I_KICK);
              is_pin_direction_load = (instr_in[4:3] == 2'b00) && (instr_in[2:0] == `BID_PIN_DIRECTION_LOAD_PORT);
            end
          end
          4'h1: begin
            op = `BID_OP_CLR;
            wr_acc = ~d_bit;
          end
          4'h2: begin
            op = `BID_OP_SUB;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          4'h3: op = `BID_OP_DEC;
          4'h4: op = `BID_OP_OR;
          4'h5: op = `BID_OP_AND;
          4'h6: op = `BID_OP_XOR;
          4'h7: begin
            op = `BID_OP_ADD;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          4'h8: op = `BID_OP_MOVB;
          4'h9: begin
            op = `BID_OP_COM;
            note_tmr = 1'b0;
          end
          4'ha: op = `BID_OP_INC;
          4'hb: begin
            op = `BID_OP_DEC;
            upd_z = 1'b0;
            skip_zero = 1'b1;
          end
          4'hc: begin
            op = `BID_OP_RR;
            upd_z = 1'b0;
            upd_c = 1'b1;
          end
          4'hd: begin
            op = `BID_OP_RL;
            upd_z = 1'b0;
            upd_c = 1'b1;
          end
          4'he: begin
            op = `BID_OP_SWAP;
            upd_z = 1'b0;
          end
          default: begin
            op = `BID_OP_INC;
            upd_z = 1'b0;
            skip_zero = 1'b1;
          end
        endcase
      end
      2'b01: begin
        case (instr_in[9:8])
          2'b00: begin
            op = `BID_OP_BCLR;
            wr_file = 1'b1;
          end
          2'b01: begin
            op = `BID_OP_BSET;
            wr_file = 1'b1;
          end
          2'b10: skip_clr = 1'b1;
          default: skip_set = 1'b1;
        endcase
      end
      2'b10: begin
        case (instr_in[9:8])
          2'b00: is_ret = 1'b1;
          2'b01: is_call = 1'b1;
          default: is_unconditional_jump = 1'b1;
        endcase
      end
      default: begin
        use_lit = 1'b1;
        wr_acc = 1'b1;
        upd_z = 1'b1;
        case (instr_in[9:8])
          2'b00: begin
            op = `BID_OP_MOVB;
            upd_z = 1'b0;
          end
          2'b01: op = `BID_OP_OR;
          2'b10: op = `BID_OP_AND;
          default: op = `BID_OP_XOR;
        endcase
      end
    endcase
  end

  bid_alu u_alu (
    .op_in(op),
    .bit_idx_in(instr_in[7:5]),
    .acc_in(acc_r),
    .opnd_in(use_lit ? lit : fval),
    .carry_in(c_r),
    .res_out(alu_res),
    .carry_out(alu_c),
    .dcarry_out(alu_dc)
  );

  always @* begin
    skip = (skip_zero && (alu_res == 8'h00)) || (skip_clr && !bit_val) ||
      (skip_set && bit_val);
    pc_nxt = pc_r + 9'h001;
    st_nxt = ST_RUN;
    if (skip) begin
      pc_nxt = pc_r + 9'h002;
    end
    if (is_unconditional_jump) begin
      pc_nxt = instr_in[8:0];
      st_nxt = ST_FLUSH;
    end else if (is_call) begin
      pc_nxt = {1'b0, lit};
      st_nxt = ST_FLUSH;
    end else if (is_ret) begin
      pc_nxt = stk_r[0];
      st_nxt = ST_FLUSH;
    end else if (wr_file && (faddr == `BID_ADDR_PCL)) begin
      pc_nxt = {1'b0, alu_res};
      st_nxt = ST_FLUSH;
    end else if (skip) begin
      st_nxt = ST_FLUSH;
    end else if (is_sleep) begin
      st_nxt = ST_SLEEP;
    end
  end

  always @(posedge clock_in) begin
    if (srst_in) begin
      st_r <= ST_RUN;
      pc_r <= `BID_PC_RST;
      stk_r[0] <= `BID_PC_RST;
      stk_r[1] <= `BID_PC_RST;
      acc_r <= `BID_W_RST;
      c_r <= 1'b0;
      dc_r <= 1'b0;
      z_r <= 1'b0;
      to_r <= 1'b1;
      pd_r <= 1'b1;
      opt_r <= `BID_OPT_RST;
      pin_direction_load_r <= `BID_PIN_DIRECTION_LOAD_RST;
      file_waddr_out <= 5'h00;
      file_wdata_out <= 8'h00;
      file_we_out <= 1'b0;
      prescaler_clear_out <= 1'b0;
      watchdog_kick_out <= 1'b0;
    end else begin
      file_we_out <= 1'b0;
      prescaler_clear_out <= 1'b0;
      watchdog_kick_out <= 1'b0;
      if (ce) begin
        case (st_r)
          ST_RUN: begin
            st_r <= st_nxt;
            pc_r <= pc_nxt;
            if (wr_acc) begin
              acc_r <= alu_res;
            end
            if (is_ret) begin
              acc_r <= lit;
              stk_r[0] <= stk_r[1];
            end
            if (is_call) begin
              stk_r[1] <= stk_r[0];
              stk_r[0] <= pc_r + 9'h001;
            end
            if (wr_file) begin
              file_waddr_out <= faddr;
              file_wdata_out <= alu_res;
              file_we_out <= 1'b1;
              prescaler_clear_out <= note_tmr && (faddr == `BID_ADDR_TMR) &&
                !opt_r[`BID_OPT_PSA];
            end
            if (upd_c) begin
              c_r <= alu_c;
            end
            if (upd_dc) begin
              dc_r <= alu_dc;
            end
            if (upd_z) begin
              z_r <= (alu_res == 8'h00);
            end
            if (is_kick) begin
              to_r <= 1'b1;
              pd_r <= 1'b1;
              watchdog_kick_out <= 1'b1;
            end
            if (is_sleep) begin
              to_r <= 1'b1;
              pd_r <= 1'b0;
              watchdog_kick_out <= 1'b1;
            end
            if (is_opt) begin
              opt_r <= acc_r;
            end
            if (is_pin_direction_load) begin
              pin_direction_load_r <= acc_r;
            end
          end
          ST_FLUSH: st_r <= ST_RUN;
          ST_SLEEP: begin
            if (wake_in) begin
              st_r <= ST_RUN;
            end
          end
          default: st_r <= ST_RUN;
        endcase
      end
    end
  end

  assign pc_out = pc_r;
  assign cycle_out = ce;
  assign pin_direction_load_out = pin_direction_load_r;
  assign acc_out = acc_r;
  assign carry_out = c_r;
  assign digit_carry_flag_out = dc_r;
  assign zero_out = z_r;
  assign timeout_flag_out = to_r;
  assign powerdown_flag_out = pd_r;
  assign option_out = opt_r;
  assign sleep_out = st_r[2];

endmodule // bid_decoder

/* tb/bid_decoder_bench.sv */
// Self-checking bench for the instruction decoder.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module bid_decoder_bench;
  logic clock_in = 0, srst_in = 1, wake_in = 0;
  logic [11:0] instr_in = 12'h000;
  logic [7:0] port_pins_in = 8'h00;
  logic [8:0] pc_out, p;
  logic [4:0] raddr, waddr;
  logic [7:0] wdata, pin_direction_load_out, acc_out, option_out;
  logic cycle_out, we, carry_out, dcf, zero_out, tmo, pwd, psc, kick, sleep_out;
  logic [7:0] mem [32];
  logic [20:0] tbl [12] = '{{12'h185, 8'h98, 1'b0}, {12'h145, 8'h10, 1'b0},
    {12'he01, 8'h00, 1'b1}, {12'h105, 8'h10, 1'b0}, {12'hd5a, 8'h5a, 1'b0},
    {12'hf5a, 8'h00, 1'b1}, {12'h040, 8'h00, 1'b1}, {12'h245, 8'hef, 1'b0},
    {12'h385, 8'h01, 1'b0}, {12'h205, 8'h10, 1'b0}, {12'h0c5, 8'h0f, 1'b0},
    {12'h285, 8'h11, 1'b0}};
  int compares = 0, miscompares = 0;
  wire [7:0] file_rdata_in = mem[raddr];
  bid_decoder bid_decoder_inst (.clock_in(clock_in), .srst_in(srst_in), .instr_in(instr_in),
    .pc_out(pc_out), .cycle_out(cycle_out), .file_raddr_out(raddr),
    .file_rdata_in(file_rdata_in), .file_waddr_out(waddr), .file_wdata_out(wdata),
    .file_we_out(we), .port_pins_in(port_pins_in), .pin_direction_load_out(pin_direction_load_out), .acc_out(acc_out),
    .carry_out(carry_out), .digit_carry_flag_out(dcf), .zero_out(zero_out),
    .timeout_flag_out(tmo), .powerdown_flag_out(pwd), .option_out(option_out),
    .prescaler_clear_out(psc), .watchdog_kick_out(kick), .wake_in(wake_in),
    .sleep_out(sleep_out));
  always #2 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    if (we) mem[waddr] <= wdata;
  end
  task automatic ex(input logic [11:0] w);
    @(posedge clock_in);
    instr_in <= w;
    do @(negedge clock_in); while (cycle_out !== 1'b1);
    @(negedge clock_in);
  endtask
  task automatic exp(input logic [11:0] w, input logic [8:0] d);
    p = pc_out;
    ex(w);
    `CHK(pc_out, p + d)
  endtask
  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 8'h00;
    mem[6] = 8'hc3;
    repeat (10) @(posedge clock_in);
    srst_in <= 1'b0;
    ex(12'hc88);
    `CHK({pc_out, acc_out}, 17'h00088)
    ex(12'h025);
    ex(12'h1e5);
    `CHK({carry_out, dcf}, 2'b11)
    ex(12'h085);
    `CHK(mem[5], 8'h10)
    `CHK({acc_out, carry_out, dcf, zero_out}, 11'h440)
    $display("arith done");
    for (int i = 0; i < 12; i++) begin
      ex(tbl[i][20:9]);
      `CHK({acc_out, zero_out}, tbl[i][8:0])
    end
    `CHK(carry_out, 1'b0)
    ex(12'hc81);
    ex(12'h027);
    ex(12'h347);
    `CHK({acc_out, carry_out}, 9'h005)
    ex(12'h307);
    `CHK({acc_out, carry_out}, 9'h181)
    $display("logic done");
    ex(12'hc01);
    ex(12'h028);
    exp(12'h2e8, 9'h002);
    ex(12'hcee);
    `CHK({mem[8], acc_out}, 16'h0001)
    exp(12'h568, 9'h001);
    exp(12'h668, 9'h001);
    `CHK(mem[8], 8'h08)
    exp(12'h768, 9'h002);
    ex(12'hcee);
    exp(12'h468, 9'h001);
    exp(12'h668, 9'h002);
    ex(12'hcee);
    `CHK(acc_out, 8'h01)
    $display("skip done");
    ex(12'hba5);
    `CHK(pc_out, 9'h1a5)
    ex(12'hcee);
    ex(12'h933);
    `CHK(pc_out, 9'h033)
    ex(12'hcee);
    ex(12'h842);
    ex(12'hcee);
    `CHK({pc_out, acc_out}, 17'h1a642)
    $display("branch done");
    ex(12'hc07);
    ex(12'h002);
    `CHK(option_out, 8'h07)
    ex(12'h021);
    `CHK(psc, 1'b1)
    ex(12'hc0f);
    ex(12'h006);
    `CHK(pin_direction_load_out, 8'h0f)
    @(posedge clock_in);
    port_pins_in <= 8'h3c;
    ex(12'h206);
    `CHK(acc_out, 8'h3c)
    $display("side effects done");
    ex(12'h004);
    `CHK({kick, tmo, pwd}, 3'b111)
    ex(12'h003);
    `CHK({sleep_out, tmo, pwd}, 3'b110)
    ex(12'hcee);
    `CHK(acc_out, 8'h3c)
    @(posedge clock_in);
    wake_in <= 1'b1;
    ex(12'hcee);
    ex(12'hc5a);
    `CHK({sleep_out, acc_out}, 9'h05a)
    $display("standby done");
    report_and_stop();
  end
endmodule // bid_decoder_bench

/* tb/bid_props.sv */
// Concurrent checks on the instruction decoder ports.
`timescale 1ns/1ps
`include "bid_consts.vh"
module bid_props (
  // Clock and reset.
  input wire clock_in,
  input wire srst_in,
  // Watched ports.
  input wire [11:0] instr_in,
  input wire [8:0] pc_out,
  input wire cycle_out,
  input wire [4:0] file_raddr_out,
  input wire [7:0] file_rdata_in,
  input wire [4:0] file_waddr_out,
  input wire file_we_out,
  input wire [7:0] pin_direction_load_out,
  input wire [7:0] acc_out,
  input wire carry_out,
  input wire digit_carry_flag_out,
  input wire powerdown_flag_out,
  input wire [7:0] option_out,
  input wire prescaler_clear_out,
  input wire watchdog_kick_out,
  input wire sleep_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  a_file_write_cause: assert property (file_we_out |-> $past(cycle_out) &&
    file_waddr_out == $past(instr_in[4:0])) else $error("Stray file write.");
  a_acc_holds: assert property (!$past(cycle_out) |-> $stable(acc_out))
    else $error("Accumulator moved off the execute edge.");
  a_jump_target: assert property (cycle_out && instr_in[11:9] == 3'b101 |=>
    pc_out == $past(instr_in[8:0]) || $stable(pc_out)) else $error("Bad jump target.");
  a_call_low_half: assert property (cycle_out && instr_in[11:8] == 4'h9 |=>
    !pc_out[8] || $stable(pc_out)) else $error("Call left the upper bit set.");
  a_skip_by_two: assert property (cycle_out && instr_in[11:8] == 4'h7 &&
    file_raddr_out != `BID_ADDR_PORT && file_rdata_in[instr_in[7:5]] |=>
    pc_out == $past(pc_out) + 9'h002 || $stable(pc_out)) else $error("Skip not taken.");
  a_kick_cause: assert property (watchdog_kick_out |-> $past(cycle_out) &&
    ($past(instr_in) == `BID_I_KICK || $past(instr_in) == `BID_I_SLEEP))
    else $error("Stray watchdog kick.");
  a_sleep_powerdown: assert property (sleep_out |-> !powerdown_flag_out)
    else $error("Power-down flag high in standby.");
  a_prescale_cause: assert property (prescaler_clear_out |-> $past(cycle_out) &&
    $past(instr_in[4:0]) == `BID_ADDR_TMR && !$past(option_out[`BID_OPT_PSA]))
    else $error("Stray prescaler clear.");
  a_option_load: assert property ($changed(option_out) |-> $past(cycle_out) &&
    $past(instr_in) == `BID_I_OPTION) else $error("Option changed without its word.");
  a_pin_direction_load_load: assert property ($changed(pin_direction_load_out) |->
    $past(instr_in) == {9'h000, `BID_PIN_DIRECTION_LOAD_PORT}) else $error("Direction changed wrongly.");
  a_literal_flags: assert property (cycle_out && instr_in[11:10] == 2'b11 |=>
    $stable(carry_out) && $stable(digit_carry_flag_out)) else $error("Literal op hit carry.");
endmodule // bid_props
bind bid_decoder bid_props bid_props_inst (.clock_in(clock_in), .srst_in(srst_in),
  .instr_in(instr_in), .pc_out(pc_out), .cycle_out(cycle_out),
  .file_raddr_out(file_raddr_out), .file_rdata_in(file_rdata_in),
  .file_waddr_out(file_waddr_out), .file_we_out(file_we_out), .pin_direction_load_out(pin_direction_load_out),
  .acc_out(acc_out), .carry_out(carry_out), .digit_carry_flag_out(digit_carry_flag_out),
  .powerdown_flag_out(powerdown_flag_out), .option_out(option_out),
  .prescaler_clear_out(prescaler_clear_out), .watchdog_kick_out(watchdog_kick_out),
  .sleep_out(sleep_out));
